/* File: inc/pc_stack_pkg.sv */
// Constants, types and state records of the program-flow and addressing block.
package pc_stack_pkg;

    localparam logic [12:0] PC_RESET     = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
    localparam logic [12:0] PC_STEP      = 13'h0001;
    localparam logic [4:0]  HOLD_RESET   = 5'h00;
    localparam logic [7:0]  FSR_RESET    = 8'h00;
    localparam logic        BANK_RESET   = 1'b0;
    localparam logic        READY_RESET  = 1'b1;
    localparam logic [2:0]  SP_RESET     = 3'h0;
    localparam logic [2:0]  SP_STEP      = 3'h1;
    localparam logic [6:0]  IND_PORT_LOC = 7'h00;

    localparam logic [7:0]  OFS_PCL      = 8'h00;
    localparam logic [7:0]  OFS_HOLD     = 8'h04;
    localparam logic [7:0]  OFS_FSR      = 8'h08;
    localparam logic [7:0]  OFS_BANK     = 8'h0C;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Every return kind uses OP_RET; they differ only in the execution unit.
    typedef enum logic [2:0] {
        OP_NONE      = 3'h0,
        OP_STEP      = 3'h1,
        OP_GOTO      = 3'h2,
        OP_CALL      = 3'h3,
        OP_IRQ       = 3'h4,
        OP_RET       = 3'h5,
        OP_WRITE_PCL = 3'h6,
        OP_ADD_PCL   = 3'h7
    } op_kind_e;

    typedef enum logic [1:0] {
        WS_IDLE = 2'b00,
        WS_RESP = 2'b01
    } wr_state_e;

    typedef struct packed {
        op_kind_e    kind;
        logic [10:0] target;
        logic [7:0]  data;
    } core_op_s;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } ind_req_s;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [8:0] addr;
        logic [7:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic [2:0]       sp;
        logic [7:0][12:0] entry;
    } stack_state_s;

    typedef struct packed {
        logic [12:0] pc;
        logic [4:0]  hold;
        logic [7:0]  file_select_pointer;
        logic        bank;
        wr_state_e   wstate;
        logic        aw_have;
        logic        w_have;
        logic [7:0]  waddr;
        logic [7:0]  wdata;
        logic        wlane0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
        mem_req_s    mem;
        logic        ind_pend;
        logic        ind_rvalid;
        logic [7:0]  ind_rdata;
    } main_state_s;

endpackage

/* File: src/return_stack.sv */
// Circular eight-entry return-address stack.
`timescale 1ns/100ps
module return_stack (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Push and pop requests
    input  wire logic        push,
    input  wire logic        pop,
    input  wire logic [12:0] push_data,
    // Entry that the next pop returns
    output logic      [12:0] top_data
);

    pc_stack_pkg::stack_state_s s_reg;
    pc_stack_pkg::stack_state_s s_next;

    // The pointer has no full or empty flag on purpose: overflow simply
    // wraps and underflow returns stale entries.
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.entry[s_reg.sp] = push_data;
            s_next.sp = s_reg.sp + pc_stack_pkg::SP_STEP;
        end else if (pop) begin
            s_next.sp = s_reg.sp - pc_stack_pkg::SP_STEP;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.sp <= pc_stack_pkg::SP_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign top_data = s_reg.entry[3'(s_reg.sp - pc_stack_pkg::SP_STEP)];

    property p_wrap_up;
        @(posedge aclk) disable iff (!aresetn)
        push && s_reg.sp == 3'h7 |=> s_reg.sp == 3'h0;
    endproperty
    AST_PUSH_WRAP: assert property (p_wrap_up)
        else $error("push at top slot did not wrap to slot zero");

    property p_wrap_down;
        @(posedge aclk) disable iff (!aresetn)
        pop && !push && s_reg.sp == 3'h0 |=> s_reg.sp == 3'h7;
    endproperty
    AST_POP_WRAP: assert property (p_wrap_down)
        else $error("pop at slot zero did not wrap to top slot");

    property p_push_pop;
        @(posedge aclk) disable iff (!aresetn)
        push ##1 (pop && !push) |-> top_data == $past(push_data);
    endproperty
    AST_PUSH_POP: assert property (p_push_pop)
        else $error("stack did not return the pushed entry");

endmodule

/* File: src/pc_stack_indirect_addr.sv */
// Program counter, return stack and indirect address unit with register port.
`timescale 1ns/100ps
module pc_stack_indirect_addr #(
    // Clear for program memories of 4K words or less.
    parameter bit BIG_MEM = 1'b1
) (
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // Register bus, write address
    input  wire logic                     awvalid,
    output logic                          awready,
    input  wire logic [7:0]               awaddr,
    // Register bus, write data
    input  wire logic                     wvalid,
    output logic                          wready,
    input  wire logic [31:0]              wdata,
    input  wire logic [3:0]               wstrb,
    // Register bus, write response
    output logic                          bvalid,
    input  wire logic                     bready,
    output logic      [1:0]               bresp,
    // Register bus, read address
    input  wire logic                     arvalid,
    output logic                          arready,
    input  wire logic [7:0]               araddr,
    // Register bus, read data
    output logic                          rvalid,
    input  wire logic                     rready,
    output logic      [31:0]              rdata,
    output logic      [1:0]               rresp,
    // Program flow commands from the execution unit
    input  wire pc_stack_pkg::core_op_s   core_op,
    output logic      [12:0]              pc_out,
    // Indirect data port access from the execution unit
    input  wire pc_stack_pkg::ind_req_s   ind_req,
    output logic                          ind_rvalid,
    output logic      [7:0]               ind_rdata,
    // Data memory access on behalf of the indirect port
    output pc_stack_pkg::mem_req_s        mem_req,
    input  wire logic [7:0]               mem_rdata
);

    pc_stack_pkg::main_state_s s_reg;
    pc_stack_pkg::main_state_s s_next;

    logic        push;
    logic        pop;
    logic [12:0] push_data;
    logic [12:0] top_data;
    logic [4:0]  page;
    logic        self_hit;
    logic        axi_pcl_wr;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == pc_stack_pkg::OFS_PCL) ||
                 (a == pc_stack_pkg::OFS_HOLD) ||
                 (a == pc_stack_pkg::OFS_FSR) ||
                 (a == pc_stack_pkg::OFS_BANK);
    endfunction

    // The top page bit is dropped on small parts so that code written for
    // a larger part never jumps into absent memory.
    function automatic logic [4:0] page_mask(input logic [4:0] h);
        page_mask = {h[4] & BIG_MEM, h[3:0]};
    endfunction

    return_stack u_stack (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .push      (push),
        .pop       (pop),
        .push_data (push_data),
        .top_data  (top_data)
    );

    // Port zero of any bank is the indirect port itself.
    assign self_hit = (s_reg.file_select_pointer[6:0] == pc_stack_pkg::IND_PORT_LOC);
    assign page = page_mask(s_reg.hold);

    always_comb begin
        s_next = s_reg;
        push = 1'b0;
        pop = 1'b0;
        push_data = s_reg.pc;
        axi_pcl_wr = 1'b0;

        // Address and data are taken in either order and held until the
        // response, so only one write is ever in flight.
        if (s_reg.awready && awvalid) begin
            s_next.aw_have = 1'b1;
            s_next.waddr = awaddr;
            s_next.awready = 1'b0;
        end
        if (s_reg.wready && wvalid) begin
            s_next.w_have = 1'b1;
            s_next.wdata = wdata[7:0];
            s_next.wlane0 = wstrb[0];
            s_next.wready = 1'b0;
        end

        unique case (s_reg.wstate)
            pc_stack_pkg::WS_IDLE: begin
                // A register write waits while the core moves the counter,
                // which keeps the two from racing on the same cycle.
                if (s_reg.aw_have && s_reg.w_have &&
                    core_op.kind == pc_stack_pkg::OP_NONE) begin
                    s_next.aw_have = 1'b0;
                    s_next.w_have = 1'b0;
                    s_next.bvalid = 1'b1;
                    s_next.wstate = pc_stack_pkg::WS_RESP;
                    s_next.bresp = mapped(s_reg.waddr) ?
                                   pc_stack_pkg::RESP_OKAY :
                                   pc_stack_pkg::RESP_SLVERR;
                    if (s_reg.wlane0) begin
                        unique case (s_reg.waddr)
                            pc_stack_pkg::OFS_PCL:
                                axi_pcl_wr = 1'b1;
                            pc_stack_pkg::OFS_HOLD:
                                s_next.hold = s_reg.wdata[4:0];
                            pc_stack_pkg::OFS_FSR:
                                s_next.file_select_pointer = s_reg.wdata;
                            pc_stack_pkg::OFS_BANK:
                                s_next.bank = s_reg.wdata[0];
                            default: begin
                            end
                        endcase
                    end
                end
            end
            pc_stack_pkg::WS_RESP: begin
                if (bready) begin
                    s_next.bvalid = 1'b0;
                    s_next.awready = 1'b1;
                    s_next.wready = 1'b1;
                    s_next.wstate = pc_stack_pkg::WS_IDLE;
                end
            end
            default: begin
                s_next.wstate = pc_stack_pkg::WS_IDLE;
            end
        endcase

        if (s_reg.arready && arvalid) begin
            s_next.arready = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp = pc_stack_pkg::RESP_OKAY;
            unique case (araddr)
                pc_stack_pkg::OFS_PCL:
                    s_next.rdata = s_reg.pc[7:0];
                pc_stack_pkg::OFS_HOLD:
                    s_next.rdata = {3'h0, s_reg.hold};
                pc_stack_pkg::OFS_FSR:
                    s_next.rdata = s_reg.file_select_pointer;
                pc_stack_pkg::OFS_BANK:
                    s_next.rdata = {7'h00, s_reg.bank};
                default: begin
                    s_next.rdata = 8'h00;
                    s_next.rresp = pc_stack_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end

        // The holding register is never touched here: only the bus
        // writes it, so calls and returns leave it as it was.
        unique case (core_op.kind)
            pc_stack_pkg::OP_NONE: begin
                if (axi_pcl_wr) begin
                    s_next.pc = {page, s_reg.wdata};
                end
            end
            pc_stack_pkg::OP_STEP: begin
                s_next.pc = s_reg.pc + pc_stack_pkg::PC_STEP;
            end
            pc_stack_pkg::OP_GOTO: begin
                s_next.pc = {page[4:3], core_op.target};
            end
            pc_stack_pkg::OP_CALL: begin
                push = 1'b1;
                push_data = s_reg.pc + pc_stack_pkg::PC_STEP;
                s_next.pc = {page[4:3], core_op.target};
            end
            pc_stack_pkg::OP_IRQ: begin
                push = 1'b1;
                push_data = s_reg.pc;
                s_next.pc = pc_stack_pkg::IRQ_VECTOR;
            end
            pc_stack_pkg::OP_RET: begin
                pop = 1'b1;
                s_next.pc = top_data;
            end
            pc_stack_pkg::OP_WRITE_PCL: begin
                s_next.pc = {page, core_op.data};
            end
            pc_stack_pkg::OP_ADD_PCL: begin
                // The low byte sum drops its carry; tables crossing a
                // 256-word block need the holding register adjusted.
                s_next.pc = {page, 8'(s_reg.pc[7:0] + core_op.data)};
            end
        endcase

        // The indirect port holds nothing; requests go to the pointed
        // location unless the pointer names the port itself.
        s_next.mem.rd = ind_req.rd && !self_hit;
        s_next.mem.wr = ind_req.wr && !self_hit;
        s_next.mem.addr = {s_reg.bank, s_reg.file_select_pointer};
        s_next.mem.wdata = ind_req.wdata;
        s_next.ind_pend = ind_req.rd;
        s_next.ind_rvalid = s_reg.ind_pend;
        s_next.ind_rdata = s_reg.mem.rd ? mem_rdata : 8'h00;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.pc <= pc_stack_pkg::PC_RESET;
            s_reg.hold <= pc_stack_pkg::HOLD_RESET;
            s_reg.file_select_pointer <= pc_stack_pkg::FSR_RESET;
            s_reg.bank <= pc_stack_pkg::BANK_RESET;
            s_reg.wstate <= pc_stack_pkg::WS_IDLE;
            s_reg.awready <= pc_stack_pkg::READY_RESET;
            s_reg.wready <= pc_stack_pkg::READY_RESET;
            s_reg.arready <= pc_stack_pkg::READY_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // No overflow or underflow flag exists anywhere in this port list.
    assign pc_out = s_reg.pc;
    assign awready = s_reg.awready;
    assign wready = s_reg.wready;
    assign bvalid = s_reg.bvalid;
    assign bresp = s_reg.bresp;
    assign arready = s_reg.arready;
    assign rvalid = s_reg.rvalid;
    assign rdata = {24'h000000, s_reg.rdata};
    assign rresp = s_reg.rresp;
    assign mem_req = s_reg.mem;
    assign ind_rvalid = s_reg.ind_rvalid;
    assign ind_rdata = s_reg.ind_rdata;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_call_then_ret;
        core_op.kind == pc_stack_pkg::OP_CALL
        ##1 core_op.kind == pc_stack_pkg::OP_RET;
    endsequence

    sequence s_self_read;
        ind_req.rd && self_hit ##1 1'b1;
    endsequence

    property p_reset_clear;
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> pc_out == 13'h0000;
    endproperty

    AST_RESET_CLEAR: assert property (p_reset_clear)
        else $error("counter not cleared by reset");

    AST_STEP_INC: assert property (
        core_op.kind == pc_stack_pkg::OP_STEP
        |=> pc_out == 13'($past(pc_out) + 13'h0001))
        else $error("step did not advance the counter by one");

    AST_PCL_LOAD: assert property (
        core_op.kind == pc_stack_pkg::OP_WRITE_PCL
        |=> pc_out == {$past(page), $past(core_op.data)})
        else $error("low byte write loaded wrong counter value");

    AST_GOTO_PAGE: assert property (
        core_op.kind == pc_stack_pkg::OP_GOTO
        |=> pc_out == {$past(page[4:3]), $past(core_op.target)})
        else $error("jump target or page bits wrong");

    AST_ADD_NOCARRY: assert property (
        core_op.kind == pc_stack_pkg::OP_ADD_PCL
        |=> pc_out[12:8] == $past(page)
            && pc_out[7:0] == 8'($past(pc_out[7:0]) + $past(core_op.data)))
        else $error("computed jump carried or summed wrongly");

    AST_CALL_RET: assert property (
        s_call_then_ret |=> pc_out == 13'($past(pc_out, 2) + 13'h0001))
        else $error("return did not resume after the call");

    AST_IRQ_VECTOR: assert property (
        core_op.kind == pc_stack_pkg::OP_IRQ
        |=> pc_out == pc_stack_pkg::IRQ_VECTOR)
        else $error("interrupt did not branch to its vector");

    AST_HOLD_STABLE: assert property (
        (core_op.kind == pc_stack_pkg::OP_CALL
         || core_op.kind == pc_stack_pkg::OP_RET
         || core_op.kind == pc_stack_pkg::OP_IRQ)
        |=> s_reg.hold == $past(s_reg.hold))
        else $error("holding register changed on push or pop");

    // Stepping past the last word may still reach bit 12, so only the
    // core loads that take page bits are watched here, not the bus load.
    AST_SMALL_PAGE: assert property (
        !BIG_MEM && (core_op.kind == pc_stack_pkg::OP_GOTO
                     || core_op.kind == pc_stack_pkg::OP_CALL
                     || core_op.kind == pc_stack_pkg::OP_WRITE_PCL
                     || core_op.kind == pc_stack_pkg::OP_ADD_PCL)
        |=> !pc_out[12])
        else $error("upper page bit used on a small part");

    AST_IND_SELF: assert property (
        s_self_read |=> ind_rvalid && ind_rdata == 8'h00)
        else $error("self-pointed indirect read not zero");

    AST_IND_NOWR: assert property (
        ind_req.wr && self_hit |=> !mem_req.wr)
        else $error("self-pointed indirect write reached memory");

    AST_IND_ADDR: assert property (
        ind_req.rd && !self_hit
        |=> mem_req.rd
            && mem_req.addr == {$past(s_reg.bank), $past(s_reg.file_select_pointer)})
        else $error("indirect address not bank bit over pointer");

    AST_IND_DATA: assert property (
        ind_req.rd && !self_hit
        ##1 1'b1 |=> ind_rvalid && ind_rdata == $past(mem_rdata))
        else $error("indirect read data not from pointed register");

    // The bus path loads the whole counter just as a core low byte write.
    AST_BUS_PCL: assert property (
        axi_pcl_wr
        |=> pc_out == {$past(page), $past(s_reg.wdata)})
        else $error("bus low byte write loaded wrong counter value");

    AST_PCL_READ: assert property (
        arvalid && arready && araddr == pc_stack_pkg::OFS_PCL
        |=> rvalid && rdata[7:0] == $past(pc_out[7:0]))
        else $error("low byte read did not return the counter");

endmodule

/* File: verification/data_mem_model.sv */
// Data memory model that answers the indirect port's memory requests.
`timescale 1ns/100ps
module data_mem_model (
    // Clock
    input  wire logic                 aclk,
    // Requests from the block
    input  wire pc_stack_pkg::mem_req_s mem_req,
    output logic [7:0]                mem_rdata
);
    logic [7:0] mem [0:511];
    logic [7:0] junk;
    initial junk = 8'h5A;
    // Outside a read the bus shows a changing pattern, so stale data never passes.
    always @(posedge aclk) begin
        junk <= ~junk;
        if (mem_req.wr) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
    end
    assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : junk;
endmodule

/* File: verification/pc_stack_indirect_addr_tb.sv */
// Self-checking bench for the program-flow and indirect address block.
`timescale 1ns/100ps
module pc_stack_indirect_addr_tb;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, ind_rvalid, v;
    logic [1:0] bresp, rresp, rs;
    logic [12:0] pc_out, pc_small;
    logic [7:0] ind_rdata, mem_rdata, q;
    pc_stack_pkg::core_op_s core_op = '0;
    pc_stack_pkg::ind_req_s ind_req = '0;
    pc_stack_pkg::mem_req_s mem_req, m;
    int num_errors = 0, n_tests = 0;
    always #4 aclk = ~aclk;
    pc_stack_indirect_addr dut_u (.aclk, .aresetn, .awvalid, .awready,
        .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .core_op, .pc_out, .ind_req, .ind_rvalid, .ind_rdata, .mem_req,
        .mem_rdata);
    // A small-memory copy sees the same stimulus; only its page bit differs.
    pc_stack_indirect_addr #(.BIG_MEM(1'b0)) dut_small_u (.aclk, .aresetn,
        .awvalid, .awready(), .awaddr, .wvalid, .wready(), .wdata, .wstrb,
        .bvalid(), .bready, .bresp(), .arvalid, .arready(), .araddr,
        .rvalid(), .rready, .rdata(), .rresp(), .core_op, .pc_out(pc_small),
        .ind_req, .ind_rvalid(), .ind_rdata(), .mem_req(), .mem_rdata);
    data_mem_model mem_u (.aclk, .mem_req, .mem_rdata);
    task automatic test_done;
        $display("counts: %0d checks, %0d mismatches", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    // A handshake that never completes ends the run at once.
    task automatic tmo(input int n);
        if (n >= 50) begin
            $display("mismatch handshake expected 1 seen 0");
            num_errors++;
            test_done();
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        int n;
        logic ad, dd;
        ad = 0; dd = 0; n = 0;
        @(posedge aclk);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d;
        wstrb <= 4'hF;
        while (!(ad && dd) && n < 50) begin
            @(posedge aclk); n++;
            if (awvalid && awready) begin ad = 1; awvalid <= 1'b0; end
            if (wvalid && wready) begin dd = 1; wvalid <= 1'b0; end
        end
        tmo(n);
        bready <= 1'b1; n = 0;
        do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 50);
        r = bresp; bready <= 1'b0;
        tmo(n);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        arvalid <= 1'b1; araddr <= a;
        do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
        arvalid <= 1'b0; rready <= 1'b1;
        do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 50);
        d = rdata; r = rresp; rready <= 1'b0;
        tmo(n);
    endtask
    task automatic op(input pc_stack_pkg::op_kind_e k, input logic [10:0] t,
                      input logic [7:0] d);
        @(posedge aclk);
        core_op <= pc_stack_pkg::core_op_s'{k, t, d};
        @(posedge aclk);
        core_op <= '0;
        #1;
    endtask
    task automatic ind_op(input logic r, w, input logic [7:0] d);
        @(posedge aclk);
        ind_req <= pc_stack_pkg::ind_req_s'{r, w, d};
        @(posedge aclk);
        ind_req <= '0;
        #1 m = mem_req;
        @(posedge aclk);
        #1 v = ind_rvalid; q = ind_rdata;
    endtask
    task automatic test_reset;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1 chk("pc_out", 32'h0, pc_out);
        axi_rd(8'h04, rv, rs);
        chk("hold", 32'h0, rv);
        $display("test reset done");
    endtask
    task automatic t_regs;
        axi_wr(8'h04, 32'h0000_00FF, rs);
        chk("bresp", 32'h0, rs);
        axi_rd(8'h04, rv, rs);
        chk("hold", 32'h1F, rv);
        axi_wr(8'h00, 32'h0000_0034, rs);
        chk("pc_out", 32'h1F34, pc_out);
        chk("pc_small", 32'h0F34, pc_small);
        axi_rd(8'h00, rv, rs);
        chk("pc_low", 32'h34, rv);
        axi_wr(8'h10, 32'h0000_0077, rs);
        chk("bresp", 32'h2, rs);
        axi_rd(8'h10, rv, rs);
        chk("rresp", 32'h2, rs);
        chk("rdata", 32'h0, rv);
        $display("test regs done");
    endtask
    task automatic t_page;
        axi_wr(8'h04, 32'h0000_000B, rs);
        op(pc_stack_pkg::OP_GOTO, 11'h123, 8'h00);
        chk("pc_out", 32'h0923, pc_out);
        op(pc_stack_pkg::OP_CALL, 11'h7FF, 8'h00);
        chk("pc_out", 32'h0FFF, pc_out);
        op(pc_stack_pkg::OP_RET, 11'h000, 8'h00);
        chk("pc_out", 32'h0924, pc_out);
        op(pc_stack_pkg::OP_WRITE_PCL, 11'h000, 8'hF0);
        chk("pc_out", 32'h0BF0, pc_out);
        op(pc_stack_pkg::OP_ADD_PCL, 11'h000, 8'h20);
        chk("pc_out", 32'h0B10, pc_out);
        op(pc_stack_pkg::OP_STEP, 11'h000, 8'h00);
        op(pc_stack_pkg::OP_IRQ, 11'h000, 8'h00);
        chk("pc_out", 32'h0004, pc_out);
        op(pc_stack_pkg::OP_RET, 11'h000, 8'h00);
        chk("pc_out", 32'h0B11, pc_out);
        // A return straight after a call must see the entry just pushed.
        @(posedge aclk);
        core_op <= pc_stack_pkg::core_op_s'{pc_stack_pkg::OP_CALL, 11'h055,
                                            8'h00};
        @(posedge aclk);
        core_op <= pc_stack_pkg::core_op_s'{pc_stack_pkg::OP_RET, 11'h000,
                                            8'h00};
        #1 chk("pc_out", 32'h0855, pc_out);
        @(posedge aclk);
        core_op <= '0;
        #1 chk("pc_out", 32'h0B12, pc_out);
        axi_rd(8'h04, rv, rs);
        chk("hold", 32'h0B, rv);
        $display("test paging done");
    endtask
    task automatic t_wrap;
        logic [12:0] pushed [0:8];
        axi_wr(8'h04, 32'h0, rs);
        op(pc_stack_pkg::OP_GOTO, 11'h100, 8'h00);
        for (int i = 0; i < 9; i++) begin
            pushed[i] = (i == 0) ? 13'h0101 : 13'(16 * i + 1);
            op(pc_stack_pkg::OP_CALL, 11'(16 * (i + 1)), 8'h00);
        end
        // The ninth pop wraps back onto the slot written by the ninth push.
        for (int j = 0; j < 9; j++) begin
            op(pc_stack_pkg::OP_RET, 11'h000, 8'h00);
            chk("pc_out", 32'(pushed[(j == 8) ? 8 : 8 - j]), pc_out);
        end
        op(pc_stack_pkg::OP_RET, 11'h000, 8'h00);
        chk("pc_out", 32'h0071, pc_out);
        $display("test stack wrap done");
    endtask
    task automatic t_ind;
        axi_wr(8'h08, 32'h25, rs);
        axi_wr(8'h0C, 32'h01, rs);
        ind_op(1'b0, 1'b1, 8'hA5);
        chk("mem_wr", 32'h1, m.wr);
        chk("mem_addr", 32'h125, m.addr);
        ind_op(1'b1, 1'b0, 8'h00);
        chk("ind_rvalid", 32'h1, v);
        chk("ind_rdata", 32'hA5, q);
        axi_wr(8'h08, 32'h80, rs);
        ind_op(1'b1, 1'b0, 8'h00);
        chk("mem_rd", 32'h0, m.rd);
        chk("ind_rdata", 32'h0, q);
        ind_op(1'b0, 1'b1, 8'h5A);
        chk("mem_wr", 32'h0, m.wr);
        axi_wr(8'h08, 32'h25, rs);
        ind_op(1'b1, 1'b0, 8'h00);
        chk("ind_rdata", 32'hA5, q);
        $display("test indirect done");
    endtask
    initial begin
        test_reset();
        t_regs();
        test_reset();
        t_page();
        t_wrap();
        t_ind();
        test_done();
    end
endmodule
